// ==== logic/bgd_display_timing.sv ====
//Contract
// - Ramp is an 8-bit counter stepping once per 12 kHz tick.
// - Left compare result is captured in a flip-flop driving the left segment.
// - Right bar source is aux or process value, compared and captured likewise.
// - Each cycle: rising ramp, return to start, then an off interval.
// - During the off interval both bar flip-flops are forced set, blanking bars.
// - A sequencer output resets the ramp to its start count.
// - A sequencer output steps the high voltage phase drivers in order.
// - Ramp bits 0, 3, 6, 7 decode sequencer timing and clock flash synchronizer; here the ramp ends at count 255, not on this decode.
// - Overrange is flagged when the compare holds past count 201.
// - Overrange toggles the bar's flash flop at 2 Hz until back to 100% or below.
// - Any of four alarm inputs flashes the bars at 4 Hz from the synchronizer.
// - Direct/reverse chooses whether the left bar grows or shrinks with the value.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bgd_display_timing #(
  parameter int OFF_TICKS = bgd_pkg::OFF_TICKS,
  parameter int FAST_DIV = bgd_pkg::FAST_DIV,
  parameter int TICK_CYCLES = bgd_pkg::TICK_CYCLES
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [7:0] outputValue, // Output value, 200 counts full scale
  input wire logic [7:0] auxValue, // Auxiliary input value
  input wire logic [7:0] processValue, // Process variable value
  input wire logic [3:0] extAlarm, // External alarm inputs, active high
  input wire logic [2:0] regAddr, // Register address
  input wire logic [7:0] regWdata, // Register write data
  input wire logic regWr, // Register write strobe
  input wire logic regRd, // Register read strobe
  output logic [7:0] regRdata, // Read data, valid cycle after strobe
  output logic leftDrive, // Left segment driver on
  output logic rightDrive, // Right segment driver on
  output logic [3:0] hvPhase, // High voltage phase drivers, one-hot
  output logic irq // Level interrupt
);
  logic [11:0] tickCnt;
  logic tick;
  logic [7:0] ramp;
  bgd_pkg::bgd_seq_state_type seqState;
  logic [7:0] offCnt;
  logic overDecode;
  logic syncStep;
  logic phaseStep;
  logic fastStep;
  logic slowStep;
  logic [1:0] ctrl;
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] next_status;
  logic extActive;
  logic [7:0] leftVal;
  logic [7:0] barVal [2];
  logic [1:0] barCmp;
  logic [1:0] barOff;
  logic [1:0] ovr;
  logic [1:0] ovrSet;
  logic [1:0] ovrTog;
  logic [1:0] extTog;
  logic [1:0] show;
  logic [1:0] drive;

  if (OFF_TICKS < 1 || OFF_TICKS > 255 || FAST_DIV < 1 || TICK_CYCLES < 2 || TICK_CYCLES > 4096) begin : g_chk
    $error("Timing parameters out of range");
  end

  // Ramp clock enable divider, 12 kHz
  always_ff @(posedge clock) begin
    if (sys_rst || tick) begin
      tickCnt <= 12'h000;
    end else begin
      tickCnt <= tickCnt + 12'h001;
    end
  end
  assign tick = (tickCnt == 12'(TICK_CYCLES - 1));

  // Sequencer: ramp, return, off interval
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seqState <= bgd_pkg::SEQ_RAMP;
      offCnt <= 8'h00;
    end else if (tick) begin
      case (seqState)
        bgd_pkg::SEQ_RAMP: begin
          if (ramp == bgd_pkg::RAMP_TOP) begin
            seqState <= bgd_pkg::SEQ_RETURN;
          end
        end
        bgd_pkg::SEQ_RETURN: begin
          seqState <= bgd_pkg::SEQ_OFF;
          offCnt <= 8'h00;
        end
        bgd_pkg::SEQ_OFF: begin
          if (offCnt == 8'(OFF_TICKS - 1)) begin
            seqState <= bgd_pkg::SEQ_RAMP;
          end else begin
            offCnt <= offCnt + 8'h01;
          end
        end
        default: seqState <= bgd_pkg::SEQ_RAMP;
      endcase
    end
  end

  // Ramp counter, reset by the return output
  always_ff @(posedge clock) begin
    if (sys_rst || seqState == bgd_pkg::SEQ_RETURN) begin
      ramp <= bgd_pkg::RAMP_START;
    end else if (tick && seqState == bgd_pkg::SEQ_RAMP && ramp != bgd_pkg::RAMP_TOP) begin
      ramp <= ramp + 8'h01;
    end
  end

  // Ramp bit decode: bits 7, 6, 3, 0 set and the rest clear, so it fires only at count 201
  assign overDecode = ramp[7] & ramp[6] & ramp[3] & ramp[0] & (ramp[5:4] == 2'b00) & (ramp[2:1] == 2'b00);
  assign syncStep = tick && seqState == bgd_pkg::SEQ_RAMP && overDecode;
  assign phaseStep = tick && seqState == bgd_pkg::SEQ_RETURN;

  // Flash rate synchronizer
  bgd_flash_rate_sync #(
    .FAST_DIV(FAST_DIV),
    .SLOW_DIV(bgd_pkg::SLOW_DIV)
  ) u_flash_rate_synchronizer (
    .clock(clock),
    .sys_rst(sys_rst),
    .step(syncStep),
    .fastStep(fastStep),
    .slowStep(slowStep)
  );

  // High voltage phase drivers rotate once per cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hvPhase <= bgd_pkg::PHASE_RESET;
    end else if (phaseStep) begin
      hvPhase <= {hvPhase[2:0], hvPhase[3]};
    end
  end

  // Bar sources
  always_comb begin
    if (ctrl[bgd_pkg::CTRL_DIRECT]) begin
      leftVal = outputValue;
    end else if (outputValue > bgd_pkg::FULL_SCALE) begin
      leftVal = 8'h00;
    end else begin
      leftVal = bgd_pkg::FULL_SCALE - outputValue;
    end
    barVal[0] = leftVal;
    barVal[1] = ctrl[bgd_pkg::CTRL_AUX] ? auxValue : processValue;
  end
  assign extActive = |extAlarm;

  // Per bar capture, overrange and flash logic
  for (genvar b = 0; b < bgd_pkg::BARS; b++) begin : g_bar
    assign barCmp[b] = barVal[b] > ramp;
    assign ovrSet[b] = syncStep && barCmp[b] && !ovr[b];

    // Display flip-flop, set during blanking
    always_ff @(posedge clock) begin
      if (sys_rst || seqState != bgd_pkg::SEQ_RAMP) begin
        barOff[b] <= 1'b1;
      end else if (tick) begin
        barOff[b] <= !barCmp[b];
      end
    end

    // Overrange flag with return at full scale
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        ovr[b] <= 1'b0;
      end else if (syncStep && barCmp[b]) begin
        ovr[b] <= 1'b1;
      end else if (tick && seqState == bgd_pkg::SEQ_RAMP && ramp == bgd_pkg::FULL_SCALE && !barCmp[b]) begin
        ovr[b] <= 1'b0;
      end
    end

    // Overrange and external alarm flash toggles
    always_ff @(posedge clock) begin
      if (sys_rst || !ovr[b]) begin
        ovrTog[b] <= 1'b1;
      end else if (slowStep) begin
        ovrTog[b] <= !ovrTog[b];
      end
    end
    always_ff @(posedge clock) begin
      if (sys_rst || !extActive) begin
        extTog[b] <= 1'b1;
      end else if (fastStep) begin
        extTog[b] <= !extTog[b];
      end
    end
    assign show[b] = ovrTog[b] & extTog[b];

    // Registered segment driver
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        drive[b] <= 1'b0;
      end else begin
        drive[b] <= !barOff[b] && show[b];
      end
    end
  end
  assign leftDrive = drive[0];
  assign rightDrive = drive[1];

  // Control and mask registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= bgd_pkg::CTRL_RESET;
      mask <= 3'h0;
    end else if (regWr) begin
      if (regAddr == bgd_pkg::REG_CTRL) begin
        ctrl <= regWdata[1:0];
      end else if (regAddr == bgd_pkg::REG_MASK) begin
        mask <= regWdata[2:0];
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_comb begin
    next_status = status;
    if (regWr && regAddr == bgd_pkg::REG_STATUS) begin
      next_status = status & ~regWdata[2:0];
    end
    next_status = next_status | {extActive && fastStep, ovrSet};
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status <= 3'h0;
    end else begin
      status <= next_status;
    end
  end
  assign irq = |(status & mask);

  // Read data, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst || !regRd) begin
      regRdata <= 8'h00;
    end else if (regAddr == bgd_pkg::REG_CTRL) begin
      regRdata <= {6'h00, ctrl};
    end else if (regAddr == bgd_pkg::REG_STATUS) begin
      regRdata <= {5'h00, status};
    end else if (regAddr == bgd_pkg::REG_MASK) begin
      regRdata <= {5'h00, mask};
    end else if (regAddr == bgd_pkg::REG_RAMP) begin
      regRdata <= ramp;
    end else if (regAddr == bgd_pkg::REG_LIVE) begin
      regRdata <= {1'b0, seqState, extActive, barOff, ovr};
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_ramp_advance: assert property (
    tick && seqState == bgd_pkg::SEQ_RAMP && ramp != bgd_pkg::RAMP_TOP |=> ramp == $past(ramp) + 8'h01)
    else $error("Ramp did not advance on tick");
  a_ramp_hold: assert property (
    !tick && seqState == bgd_pkg::SEQ_RAMP |=> $stable(ramp))
    else $error("Ramp moved without tick");
  a_left_capture: assert property (
    tick && seqState == bgd_pkg::SEQ_RAMP |=> barOff[0] == ($past(leftVal) <= $past(ramp)))
    else $error("Left capture wrong");
  a_right_select: assert property (
    tick && seqState == bgd_pkg::SEQ_RAMP && ctrl[bgd_pkg::CTRL_AUX]
    |=> barOff[1] == ($past(auxValue) <= $past(ramp)))
    else $error("Right source capture wrong");
  a_off_blank: assert property (
    seqState == bgd_pkg::SEQ_OFF |=> barOff == 2'b11 ##1 !leftDrive && !rightDrive)
    else $error("Bars not blanked in off interval");
  a_blank_wins: assert property (
    tick && seqState != bgd_pkg::SEQ_RAMP && barCmp[0] |=> barOff[0])
    else $error("Compare overrode blanking");
  a_cycle_order: assert property (
    seqState == bgd_pkg::SEQ_RAMP && tick && ramp == bgd_pkg::RAMP_TOP
    |=> seqState == bgd_pkg::SEQ_RETURN ##1 ramp == bgd_pkg::RAMP_START)
    else $error("Ramp return sequence broken");
  a_return_reset: assert property (
    seqState == bgd_pkg::SEQ_RETURN |=> ramp == bgd_pkg::RAMP_START)
    else $error("Ramp not reset on return");
  a_phase_rotate: assert property (
    phaseStep |=> hvPhase == {$past(hvPhase[2:0]), $past(hvPhase[3])} && $onehot(hvPhase))
    else $error("Phase drive did not rotate");
  a_decode_bits: assert property (
    syncStep |-> ramp == bgd_pkg::OVR_COUNT)
    else $error("Decode not at count 201");
  a_ovr_set: assert property (
    syncStep && barVal[0] > bgd_pkg::OVR_COUNT |=> ovr[0])
    else $error("Overrange not flagged");
  a_ovr_toggle: assert property (
    slowStep && ovr[0] |=> ovrTog[0] != $past(ovrTog[0]))
    else $error("Overrange flash did not toggle");
  a_ext_toggle: assert property (
    fastStep && extActive |=> extTog[1] != $past(extTog[1]))
    else $error("Alarm flash did not toggle");
  a_reverse_val: assert property (
    !ctrl[bgd_pkg::CTRL_DIRECT] && outputValue <= bgd_pkg::FULL_SCALE
    |-> leftVal + outputValue == bgd_pkg::FULL_SCALE)
    else $error("Reverse mapping wrong");
  a_flash_gate: assert property (
    !show[0] |=> !leftDrive)
    else $error("Flash off half not blanked");

  c_overrange: cover property (ovr[0] && slowStep);
  c_ext_flash: cover property (extActive && fastStep ##1 !rightDrive);
  c_full_cycle: cover property (phaseStep ##1 seqState == bgd_pkg::SEQ_OFF);
  c_irq: cover property (irq && regWr && regAddr == bgd_pkg::REG_STATUS);
endmodule
`default_nettype wire

// ==== inc/bgd_pkg.sv ====
package bgd_pkg;
  // Clock and ramp timing
  localparam int CLK_HZ = 25_000_000;
  localparam int RAMP_CLK_HZ = 12_000;
  localparam int TICK_CYCLES = CLK_HZ / RAMP_CLK_HZ;
  localparam int TICK_W = 12;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
  localparam int RAMP_W = 8;
  localparam logic [7:0] RAMP_TOP = 8'hFF;
  localparam logic [7:0] RAMP_START = 8'h00;
  localparam logic [7:0] FULL_SCALE = 8'hC8;
  localparam logic [7:0] OVR_COUNT = 8'hC9;
  localparam int OFF_TICKS = 43;
  localparam int CYCLE_TICKS = 256 + 1 + OFF_TICKS;
  localparam int CYCLE_HZ = RAMP_CLK_HZ / CYCLE_TICKS;
  localparam int FAST_FLASH_HZ = 4;
  localparam int SLOW_FLASH_HZ = 2;
  localparam int FAST_DIV = CYCLE_HZ / (2 * FAST_FLASH_HZ);
  localparam int SLOW_DIV = FAST_FLASH_HZ / SLOW_FLASH_HZ;
  localparam int ALARM_INPUTS = 4;
  localparam int BARS = 2;
  // Register map
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_MASK = 3'h2;
  localparam logic [2:0] REG_RAMP = 3'h3;
  localparam logic [2:0] REG_LIVE = 3'h4;
  localparam int CTRL_DIRECT = 0;
  localparam int CTRL_AUX = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_OVR_LEFT = 0;
  localparam int ST_EXT = 2;
  localparam int ST_W = 3;
  localparam logic [3:0] PHASE_RESET = 4'h1;
  typedef enum logic [1:0] {SEQ_RAMP, SEQ_RETURN, SEQ_OFF} bgd_seq_state_type;
endpackage

// ==== logic/bgd_flash_rate_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module bgd_flash_rate_sync #(
  parameter int FAST_DIV = bgd_pkg::FAST_DIV,
  parameter int SLOW_DIV = bgd_pkg::SLOW_DIV
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic step, // One pulse per ramp cycle
  output logic fastStep, // Half period pulse of fast flash
  output logic slowStep // Half period pulse of slow flash
);
  logic [7:0] fastCnt;
  logic [7:0] slowCnt;

  if (FAST_DIV < 1 || FAST_DIV > 255 || SLOW_DIV < 1 || SLOW_DIV > 255) begin : g_chk
    $error("Flash dividers out of range");
  end

  // Divide ramp cycles into fast flash half periods
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fastCnt <= 8'h00;
      fastStep <= 1'b0;
    end else begin
      fastStep <= 1'b0;
      if (step) begin
        if (fastCnt == 8'(FAST_DIV - 1)) begin
          fastCnt <= 8'h00;
          fastStep <= 1'b1;
        end else begin
          fastCnt <= fastCnt + 8'h01;
        end
      end
    end
  end

  // Divide fast half periods into slow ones
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slowCnt <= 8'h00;
      slowStep <= 1'b0;
    end else begin
      slowStep <= 1'b0;
      if (step && fastCnt == 8'(FAST_DIV - 1)) begin
        if (slowCnt == 8'(SLOW_DIV - 1)) begin
          slowCnt <= 8'h00;
          slowStep <= 1'b1;
        end else begin
          slowCnt <= slowCnt + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/bgd_hv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bgd_hv_model (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [3:0] hvPhase, // Phase drive from the block
  output logic [7:0] faultCnt // Count of illegal phase steps
);
  logic [3:0] lastPhase;
  // Drivers accept only a one-hot phase that holds or steps left by one position
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lastPhase <= 4'h1;
      faultCnt <= 8'h00;
    end else begin
      lastPhase <= hvPhase;
      if (!$onehot(hvPhase)) begin
        faultCnt <= faultCnt + 8'h01;
      end else if (hvPhase !== lastPhase && hvPhase !== {lastPhase[2:0], lastPhase[3]}) begin
        faultCnt <= faultCnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, sys_rst, regWr, regRd, leftDrive, rightDrive, irq;
  logic [7:0] outputValue, auxValue, processValue, regWdata, regRdata, rd, r0, faultCnt;
  logic [3:0] extAlarm, hvPhase;
  logic [2:0] regAddr;
  int error_cnt, check_count, cycles;
  typedef struct {logic [1:0] ctrl; logic [7:0] ov, av, pv; logic el, er;} bgd_row_type;
  bgd_row_type rows [7];
  localparam int T = 16;
  localparam int OFF = 1;
  localparam int CYC = (256 + 1 + OFF) * T;
  bgd_display_timing #(.OFF_TICKS(OFF), .FAST_DIV(1), .TICK_CYCLES(T)) uut (.clock(clock), .sys_rst(sys_rst),
    .outputValue(outputValue), .auxValue(auxValue), .processValue(processValue), .extAlarm(extAlarm),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .leftDrive(leftDrive), .rightDrive(rightDrive), .hvPhase(hvPhase), .irq(irq));
  bgd_hv_model hv (.clock(clock), .sys_rst(sys_rst), .hvPhase(hvPhase), .faultCnt(faultCnt));
  // Clock at 25 MHz
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard: four ramp cycles of tests plus margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 25000) begin
      error_cnt = error_cnt + 1;
      results();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rdr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic reset_checks();
    chk("hvPhase", bgd_pkg::PHASE_RESET, {4'h0, hvPhase});
    chk("drives", 8'h00, {6'h00, leftDrive, rightDrive});
    chk("irq", 8'h00, {7'h00, irq});
    wr(bgd_pkg::REG_RAMP, 8'h55); // Read-only place ignores writes
    rdr(bgd_pkg::REG_RAMP, rd);
    chk("ramp", bgd_pkg::RAMP_START, rd);
    rdr(bgd_pkg::REG_CTRL, rd);
    chk("ctrl", {6'h00, bgd_pkg::CTRL_RESET}, rd);
    rdr(bgd_pkg::REG_MASK, rd);
    chk("mask", 8'h00, rd);
    rdr(bgd_pkg::REG_STATUS, rd);
    chk("status", 8'h00, rd);
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 3'h0; regWdata = 8'h00;
    outputValue = 8'h00; auxValue = 8'h00; processValue = 8'h00; extAlarm = 4'h0;
    error_cnt = 0; check_count = 0; cycles = 0;
    rows[0] = '{2'h1, 8'hC8, 8'h00, 8'h00, 1'b1, 1'b0};
    rows[1] = '{2'h1, 8'h00, 8'hC8, 8'hC8, 1'b0, 1'b1};
    rows[2] = '{2'h0, 8'h00, 8'h00, 8'hC8, 1'b1, 1'b1};
    rows[3] = '{2'h0, 8'hC8, 8'h00, 8'hC8, 1'b0, 1'b1};
    rows[4] = '{2'h0, 8'hE6, 8'hC8, 8'h00, 1'b0, 1'b0};
    rows[5] = '{2'h2, 8'h00, 8'hC8, 8'h00, 1'b1, 1'b1};
    rows[6] = '{2'h3, 8'hC8, 8'h00, 8'hC8, 1'b1, 1'b0};
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    reset_checks();
    rdr(3'h5, rd);
    chk("unmapped", 8'h00, rd);
    // Ramp steps once per tick: reads spaced ten ticks apart
    rdr(bgd_pkg::REG_RAMP, r0);
    repeat (10 * T - 2) @(posedge clock);
    rdr(bgd_pkg::REG_RAMP, rd);
    chk("ramp step", r0 + 8'h0A, rd);
    rdr(bgd_pkg::REG_LIVE, rd);
    chk("seq state", 8'h00, rd & 8'h60);
    // Bar compare rows, each settled over two ticks
    foreach (rows[i]) begin
      @(posedge clock);
      outputValue <= rows[i].ov;
      auxValue <= rows[i].av;
      processValue <= rows[i].pv;
      wr(bgd_pkg::REG_CTRL, {6'h00, rows[i].ctrl});
      repeat (2 * T) @(posedge clock);
      #1;
      chk("leftDrive", {7'h00, rows[i].el}, {7'h00, leftDrive});
      chk("rightDrive", {7'h00, rows[i].er}, {7'h00, rightDrive});
    end
    // Each alarm input raises the alarm flag alone
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      extAlarm <= 4'(1 << k);
      repeat (4) @(posedge clock);
      rdr(bgd_pkg::REG_LIVE, rd);
      chk("alarm live", 8'h10, rd & 8'h10);
      @(posedge clock);
      extAlarm <= 4'h0;
      repeat (4) @(posedge clock);
      rdr(bgd_pkg::REG_LIVE, rd);
      chk("alarm idle", 8'h00, rd & 8'h10);
    end
    // Mask readback, clearing an empty status keeps the interrupt low
    wr(bgd_pkg::REG_MASK, 8'h07);
    rdr(bgd_pkg::REG_MASK, rd);
    chk("mask", 8'h07, rd);
    wr(bgd_pkg::REG_STATUS, 8'h07);
    rdr(bgd_pkg::REG_STATUS, rd);
    chk("status", 8'h00, rd);
    chk("irq", 8'h00, {7'h00, irq});
    // Overrange on both bars sets sticky status and the interrupt
    @(posedge clock);
    outputValue <= 8'hE6;
    processValue <= 8'hCA;
    wr(bgd_pkg::REG_CTRL, 8'h01);
    repeat (CYC) @(posedge clock);
    rdr(bgd_pkg::REG_STATUS, rd);
    chk("ovr status", 8'h03, rd);
    chk("ovr irq", 8'h01, {7'h00, irq});
    rdr(bgd_pkg::REG_LIVE, rd);
    chk("ovr live", 8'h03, rd & 8'h03);
    wr(bgd_pkg::REG_STATUS, 8'h03);
    rdr(bgd_pkg::REG_STATUS, rd);
    chk("ovr clear", 8'h00, rd);
    // Values back at or below full scale end the flash
    @(posedge clock);
    outputValue <= bgd_pkg::FULL_SCALE;
    processValue <= 8'h64;
    repeat (CYC) @(posedge clock);
    rdr(bgd_pkg::REG_LIVE, rd);
    chk("ovr end", 8'h00, rd & 8'h03);
    // An alarm input sets the flash status on its half periods
    @(posedge clock);
    extAlarm <= 4'h4;
    repeat (CYC) @(posedge clock);
    rdr(bgd_pkg::REG_STATUS, rd);
    chk("alarm status", 8'h04, rd);
    chk("alarm irq", 8'h01, {7'h00, irq});
    @(posedge clock);
    extAlarm <= 4'h0;
    wr(bgd_pkg::REG_STATUS, 8'h04);
    rdr(bgd_pkg::REG_STATUS, rd);
    chk("alarm clear", 8'h00, rd);
    // Phase drive steps left once per ramp cycle
    r0 = {4'h0, hvPhase};
    repeat (CYC) @(posedge clock);
    #1;
    chk("hv rotate", {4'h0, r0[2:0], r0[3]}, {4'h0, hvPhase});
    // Second reset in mid-run
    wr(bgd_pkg::REG_CTRL, 8'h02);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    reset_checks();
    chk("hv faults", 8'h00, faultCnt);
    results();
  end
endmodule
`default_nettype wire
